/* File: sdr_amp_rom.sv */
module sdr_amp_rom
    import sdr_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [4:0] level_in,
    output logic      [9:0] amp_ma_out
);

    logic [9:0] amp_d;

    always_comb
    begin
        case (level_in)
            5'h00: amp_d = 10'h00f;
            5'h01: amp_d = 10'h01e;
            5'h02: amp_d = 10'h02d;
            5'h03: amp_d = 10'h032;
            5'h04: amp_d = 10'h037;
            5'h05: amp_d = 10'h03d;
            5'h06: amp_d = 10'h043;
            5'h07: amp_d = 10'h04a;
            5'h08: amp_d = 10'h052;
            5'h09: amp_d = 10'h05b;
            5'h0a: amp_d = 10'h064;
            5'h0b: amp_d = 10'h06e;
            5'h0c: amp_d = 10'h07a;
            5'h0d: amp_d = 10'h087;
            5'h0e: amp_d = 10'h095;
            5'h0f: amp_d = 10'h0a4;
            5'h10: amp_d = 10'h0b5;
            5'h11: amp_d = 10'h0c8;
            5'h12: amp_d = 10'h0dd;
            5'h13: amp_d = 10'h0f4;
            5'h14: amp_d = 10'h10d;
            5'h15: amp_d = 10'h129;
            5'h16: amp_d = 10'h148;
            5'h17: amp_d = 10'h16a;
            5'h18: amp_d = 10'h190;
            5'h19: amp_d = 10'h1b9;
            5'h1a: amp_d = 10'h1e7;
            5'h1b: amp_d = 10'h21a;
            5'h1c: amp_d = 10'h252;
            5'h1d: amp_d = 10'h290;
            5'h1e: amp_d = 10'h2d4;
            default: amp_d = 10'h320;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            amp_ma_out <= 10'h000;
        else
            amp_ma_out <= amp_d;
    end

endmodule : sdr_amp_rom

/* File: sdr_host_model.sv */
module sdr_host_model
    import sdr_pkg::*;
(
    input  wire logic clk_in,
    output sdr_req_t  req_out,
    output logic      valid_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        req_out   = '0;
        valid_out = 1'b0;
    end
    // One register access: request held across one rising edge, then the bus is scrambled.
    task automatic access(input logic wr, input logic [4:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        req_out   = {wr, addr, data};
        valid_out = 1'b1;
        @(negedge clk_in);
        valid_out = 1'b0;
        req_out   = ~req_out;
    endtask : access
endmodule : sdr_host_model

/* File: sdr_pkg.sv */
package sdr_pkg;

    localparam logic [4:0] ADDR_CFG_STEP = 5'h01;
    localparam logic [4:0] ADDR_CFG_PWM  = 5'h02;
    localparam logic [4:0] ADDR_DRV_CTRL = 5'h03;
    localparam logic [4:0] ADDR_FLT_STAT = 5'h04;

    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [7:0] DRV_CTRL_MASK = 8'hf0;
    localparam logic [6:0] FLT_MASK      = 7'h6c;

    localparam int BIT_OUT_EN   = 7;
    localparam int BIT_SLEEP    = 6;
    localparam int BIT_LA_GAIN  = 5;
    localparam int BIT_LA_HOLD  = 4;
    localparam int BIT_DIR_INV  = 7;
    localparam int BIT_EDGE_SEL = 6;
    localparam int BIT_PWM_DBL  = 3;
    localparam int BIT_JITTER   = 2;
    localparam int BIT_PARITY   = 7;
    localparam int BIT_HEAT     = 6;
    localparam int BIT_CP_FAIL  = 5;
    localparam int BIT_OPEN_X   = 3;
    localparam int BIT_OPEN_Y   = 2;

    localparam int PWM_BASE_HZ_X10 = 228;
    localparam int PWM_DBL_HZ_X10  = 456;

    typedef enum logic [2:0] {
        SDR_STEP_32,
        SDR_STEP_16,
        SDR_STEP_8,
        SDR_STEP_4,
        SDR_STEP_HALF_UNCOMP,
        SDR_STEP_HALF_COMP,
        SDR_STEP_FULL,
        SDR_STEP_RSVD
    } sdr_step_t;

    typedef struct packed {
        logic       wr;
        logic [4:0] addr;
        logic [7:0] data;
    } sdr_req_t;

    typedef struct packed {
        logic       out_en;
        logic       sleep;
        logic       la_gain_quarter;
        logic       la_hold;
        logic       pwm_double;
        logic       pwm_jitter;
        logic       edge_falling;
        logic       dir_invert;
        logic [1:0] edge_slew_select;
        sdr_step_t  step_resolution;
        logic [4:0] peak_coil_level;
    } sdr_cfg_t;

    typedef struct packed {
        logic heat_warning;
        logic cp_fail;
        logic coil_x_unconnected;
        logic coil_y_unconnected;
    } sdr_flt_t;

    function automatic logic odd_ones(input logic [6:0] v);
        odd_ones = ^v;
    endfunction : odd_ones

endpackage : sdr_pkg

/* File: sdr_regs.sv */
// Summary of operation
// - Control register at 03h: enable, sleep, gain, hold in bits 7..4; reset zero.
// - Hold bit clear passes load angle output through; set freezes it.
// - Gain bit zero scales load angle by one half, one by one quarter.
// - PWM-double bit picks 22.8 or 45.6 kHz; jitter bit enables jitter.
// - Enable bit drives bridge outputs; sleep bit selects sleep mode.
// - Rotation sense is direction pin XOR invert bit; equal means clockwise.
// - Step advances on rising step pin edge, or falling when edge bit set.
// - Five-bit peak level maps through fixed table from 15 to 800 mA.
// - Two-bit slew code selects 150, 100, 50 or 25 V/us.
// - Step code 0..6 selects 1/32 down to full step; 7 reserved.
// - Status register 04h is read only, reset zero, fixed flag layout.
// - Status bit 7 is one when bits 6..0 hold an odd count of ones.
// - Writes to read-only status registers change nothing.
module sdr_regs
    import sdr_pkg::*;
(
    input  wire logic       CORE_CLK_IN,
    input  wire logic       RST_N_IN,
    input  wire logic       REQ_VALID_IN,
    input  wire logic       REQ_WR_IN,
    input  wire logic [4:0] REQ_ADDR_IN,
    input  wire logic [7:0] REQ_DATA_IN,
    output logic      [7:0] RD_DATA_OUT,
    input  wire logic       STEP_ADVANCE_PIN_IN,
    input  wire logic       DIR_PIN_IN,
    input  wire logic       HEAT_WARNING_IN,
    input  wire logic       CP_FAIL_IN,
    input  wire logic       COIL_X_UNCONNECTED_IN,
    input  wire logic       COIL_Y_UNCONNECTED_IN,
    input  wire logic [7:0] LOAD_ANGLE_RAW_IN,
    output logic      [7:0] LOAD_ANGLE_OUTPUT_OUT,
    output logic            BRIDGE_EN_OUT,
    output logic            SLEEP_OUT,
    output logic            PWM_DOUBLE_OUT,
    output logic            PWM_JITTER_OUT,
    output logic      [8:0] PWM_FREQ_HZ_X10_OUT,
    output logic            DIR_CCW_OUT,
    output logic            STEP_PULSE_OUT,
    output logic      [4:0] PEAK_COIL_LEVEL_OUT,
    output logic      [9:0] PEAK_COIL_AMPLITUDE_OUT,
    output logic      [1:0] EDGE_SLEW_SELECT_OUT,
    output logic      [7:0] SLEW_V_PER_US_OUT,
    output logic      [2:0] STEP_RESOLUTION_OUT,
    output logic      [5:0] STEP_DIVIDER_OUT,
    output logic            STEP_COMPENSATED_OUT
);

    sdr_req_t   req;
    sdr_cfg_t   cfg;
    sdr_flt_t   flt;
    logic [7:0] step_reg_q;
    logic [7:0] pwm_reg_q;
    logic [7:0] drv_reg_q;
    logic [7:0] stat_q;
    logic [7:0] stat_d;
    sdr_step_t  mode_q;
    logic       step_pin_q;
    logic [7:0] rd_d;
    logic [7:0] la_d;

    assign req = '{wr: REQ_WR_IN, addr: REQ_ADDR_IN, data: REQ_DATA_IN};

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            step_reg_q <= RST_BYTE;
            pwm_reg_q  <= RST_BYTE;
            drv_reg_q  <= RST_BYTE;
        end
        else if (REQ_VALID_IN && req.wr)
        begin
            case (req.addr)
                ADDR_CFG_STEP: step_reg_q <= req.data;
                ADDR_CFG_PWM:  pwm_reg_q  <= req.data;
                ADDR_DRV_CTRL: drv_reg_q  <= req.data & DRV_CTRL_MASK;
                default:       step_reg_q <= step_reg_q;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            mode_q <= SDR_STEP_32;
        else if (sdr_step_t'(step_reg_q[7:5]) != SDR_STEP_RSVD)
            mode_q <= sdr_step_t'(step_reg_q[7:5]);
    end

    always_comb
    begin
        cfg.out_en           = drv_reg_q[BIT_OUT_EN];
        cfg.sleep            = drv_reg_q[BIT_SLEEP];
        cfg.la_gain_quarter  = drv_reg_q[BIT_LA_GAIN];
        cfg.la_hold          = drv_reg_q[BIT_LA_HOLD];
        cfg.pwm_double       = pwm_reg_q[BIT_PWM_DBL];
        cfg.pwm_jitter       = pwm_reg_q[BIT_JITTER];
        cfg.edge_falling     = pwm_reg_q[BIT_EDGE_SEL];
        cfg.dir_invert       = pwm_reg_q[BIT_DIR_INV];
        cfg.edge_slew_select = pwm_reg_q[1:0];
        cfg.step_resolution  = mode_q;
        cfg.peak_coil_level  = step_reg_q[4:0];
    end

    assign flt = '{heat_warning: HEAT_WARNING_IN, cp_fail: CP_FAIL_IN,
                   coil_x_unconnected: COIL_X_UNCONNECTED_IN,
                   coil_y_unconnected: COIL_Y_UNCONNECTED_IN};

    always_comb
    begin
        stat_d                 = 8'h00;
        stat_d[BIT_HEAT]       = flt.heat_warning;
        stat_d[BIT_CP_FAIL]    = flt.cp_fail;
        stat_d[BIT_OPEN_X]     = flt.coil_x_unconnected;
        stat_d[BIT_OPEN_Y]     = flt.coil_y_unconnected;
        stat_d[BIT_PARITY]     = odd_ones(stat_d[6:0] & FLT_MASK);
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            stat_q <= RST_BYTE;
        else
            stat_q <= stat_d;
    end

    always_comb
    begin
        case (req.addr)
            ADDR_CFG_STEP: rd_d = step_reg_q;
            ADDR_CFG_PWM:  rd_d = pwm_reg_q;
            ADDR_DRV_CTRL: rd_d = drv_reg_q;
            ADDR_FLT_STAT: rd_d = stat_q;
            default:       rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            RD_DATA_OUT <= RST_BYTE;
        else if (REQ_VALID_IN && !req.wr)
            RD_DATA_OUT <= rd_d;
    end

    always_comb
    begin
        if (cfg.la_gain_quarter)
            la_d = {2'b00, LOAD_ANGLE_RAW_IN[7:2]};
        else
            la_d = {1'b0, LOAD_ANGLE_RAW_IN[7:1]};
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            LOAD_ANGLE_OUTPUT_OUT <= 8'h00;
        else if (!cfg.la_hold)
            LOAD_ANGLE_OUTPUT_OUT <= la_d;
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            step_pin_q     <= 1'b0;
            STEP_PULSE_OUT <= 1'b0;
        end
        else
        begin
            step_pin_q     <= STEP_ADVANCE_PIN_IN;
            STEP_PULSE_OUT <= cfg.edge_falling ? (step_pin_q && !STEP_ADVANCE_PIN_IN)
                                               : (!step_pin_q && STEP_ADVANCE_PIN_IN);
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            BRIDGE_EN_OUT        <= 1'b0;
            SLEEP_OUT            <= 1'b0;
            PWM_DOUBLE_OUT       <= 1'b0;
            PWM_JITTER_OUT       <= 1'b0;
            PWM_FREQ_HZ_X10_OUT  <= 9'(PWM_BASE_HZ_X10);
            DIR_CCW_OUT          <= 1'b0;
            PEAK_COIL_LEVEL_OUT  <= 5'h00;
            EDGE_SLEW_SELECT_OUT <= 2'h0;
            SLEW_V_PER_US_OUT    <= 8'h96;
            STEP_RESOLUTION_OUT  <= 3'h0;
            STEP_DIVIDER_OUT     <= 6'h20;
            STEP_COMPENSATED_OUT <= 1'b0;
        end
        else
        begin
            BRIDGE_EN_OUT        <= cfg.out_en;
            SLEEP_OUT            <= cfg.sleep;
            PWM_DOUBLE_OUT       <= cfg.pwm_double;
            PWM_JITTER_OUT       <= cfg.pwm_jitter;
            PWM_FREQ_HZ_X10_OUT  <= cfg.pwm_double ? 9'(PWM_DBL_HZ_X10)
                                                   : 9'(PWM_BASE_HZ_X10);
            DIR_CCW_OUT          <= DIR_PIN_IN ^ cfg.dir_invert;
            PEAK_COIL_LEVEL_OUT  <= cfg.peak_coil_level;
            EDGE_SLEW_SELECT_OUT <= cfg.edge_slew_select;
            case (cfg.edge_slew_select)
                2'h0:    SLEW_V_PER_US_OUT <= 8'h96;
                2'h1:    SLEW_V_PER_US_OUT <= 8'h64;
                2'h2:    SLEW_V_PER_US_OUT <= 8'h32;
                default: SLEW_V_PER_US_OUT <= 8'h19;
            endcase
            STEP_RESOLUTION_OUT  <= cfg.step_resolution;
            STEP_COMPENSATED_OUT <= (cfg.step_resolution == SDR_STEP_HALF_COMP);
            case (cfg.step_resolution)
                SDR_STEP_32:          STEP_DIVIDER_OUT <= 6'h20;
                SDR_STEP_16:          STEP_DIVIDER_OUT <= 6'h10;
                SDR_STEP_8:           STEP_DIVIDER_OUT <= 6'h08;
                SDR_STEP_4:           STEP_DIVIDER_OUT <= 6'h04;
                SDR_STEP_HALF_UNCOMP: STEP_DIVIDER_OUT <= 6'h02;
                SDR_STEP_HALF_COMP:   STEP_DIVIDER_OUT <= 6'h02;
                default:              STEP_DIVIDER_OUT <= 6'h01;
            endcase
        end
    end

    sdr_amp_rom u_amp_rom (
        .clk_in     (CORE_CLK_IN),
        .rst_n_in   (RST_N_IN),
        .level_in   (cfg.peak_coil_level),
        .amp_ma_out (PEAK_COIL_AMPLITUDE_OUT)
    );

endmodule : sdr_regs

/* File: sdr_regs_checker.sv */
module sdr_regs_checker
    import sdr_pkg::*;
(
    input wire logic       CORE_CLK_IN,
    input wire logic       RST_N_IN,
    input wire logic       REQ_VALID_IN,
    input wire logic       REQ_WR_IN,
    input wire logic [4:0] REQ_ADDR_IN,
    input wire logic [7:0] REQ_DATA_IN,
    input wire logic [7:0] RD_DATA_OUT,
    input wire logic       STEP_ADVANCE_PIN_IN,
    input wire logic       BRIDGE_EN_OUT,
    input wire logic       SLEEP_OUT,
    input wire logic [8:0] PWM_FREQ_HZ_X10_OUT,
    input wire logic [7:0] SLEW_V_PER_US_OUT,
    input wire logic       STEP_PULSE_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wr_go;
    logic rd_go;
    assign wr_go = REQ_VALID_IN && REQ_WR_IN;
    assign rd_go = REQ_VALID_IN && !REQ_WR_IN;
    default clocking @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    bridge_follow_a:
        assert property (wr_go && REQ_ADDR_IN == ADDR_DRV_CTRL |-> ##2
            BRIDGE_EN_OUT == $past(REQ_DATA_IN[7], 2)) else $error("Bridge enable wrong.");
    sleep_follow_a:
        assert property (wr_go && REQ_ADDR_IN == ADDR_DRV_CTRL |-> ##2
            SLEEP_OUT == $past(REQ_DATA_IN[6], 2)) else $error("Sleep level wrong.");
    pwm_rate_a:
        assert property (wr_go && REQ_ADDR_IN == ADDR_CFG_PWM |-> ##2 PWM_FREQ_HZ_X10_OUT
            == ($past(REQ_DATA_IN[3], 2) ? 9'h1c8 : 9'h0e4)) else $error("PWM rate wrong.");
    slew_rate_a:
        assert property (wr_go && REQ_ADDR_IN == ADDR_CFG_PWM |-> ##2 SLEW_V_PER_US_OUT ==
            ($past(REQ_DATA_IN[1:0], 2) == 2'h0 ? 8'h96 : $past(REQ_DATA_IN[1:0], 2) == 2'h1
            ? 8'h64 : $past(REQ_DATA_IN[1:0], 2) == 2'h2 ? 8'h32 : 8'h19))
        else $error("Slew rate wrong.");
    parity_even_a:
        assert property (rd_go && REQ_ADDR_IN == ADDR_FLT_STAT |=> !(^RD_DATA_OUT)
            && RD_DATA_OUT[4] == 1'b0 && RD_DATA_OUT[1:0] == 2'h0) else $error("Status bad.");
    ctl_nibble_a:
        assert property (rd_go && REQ_ADDR_IN == ADDR_DRV_CTRL |=> RD_DATA_OUT[3:0] == 4'h0)
        else $error("Unused control bits not zero.");
    unmapped_zero_a:
        assert property (rd_go && (REQ_ADDR_IN == 5'h00 || REQ_ADDR_IN > 5'h04) |=>
            RD_DATA_OUT == 8'h00) else $error("Unmapped read not zero.");
    step_edge_a:
        assert property (STEP_PULSE_OUT |-> $past(STEP_ADVANCE_PIN_IN) !=
            $past(STEP_ADVANCE_PIN_IN, 2)) else $error("Step pulse without pin edge.");
endmodule : sdr_regs_checker

bind sdr_regs sdr_regs_checker chk_u
(
    .CORE_CLK_IN, .RST_N_IN, .REQ_VALID_IN, .REQ_WR_IN, .REQ_ADDR_IN, .REQ_DATA_IN,
    .RD_DATA_OUT, .STEP_ADVANCE_PIN_IN, .BRIDGE_EN_OUT, .SLEEP_OUT, .PWM_FREQ_HZ_X10_OUT,
    .SLEW_V_PER_US_OUT, .STEP_PULSE_OUT
);

/* File: testbench.sv */
module testbench;
    import sdr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, step = 1'b0, dir = 1'b0, ht = 1'b0, cp = 1'b0;
    logic ox = 1'b0, oy = 1'b0, valid, br, slp, jit, ccw, pls, comp, pdbl;
    logic [4:0] lvl;
    logic [1:0] esel;
    logic [7:0] la_raw = 8'hc8, rd, la, slew, v;
    logic [8:0] freq;
    logic [9:0] amp;
    logic [2:0] res;
    logic [5:0] dv;
    sdr_req_t req;
    int mismatches = 0, n_tests = 0, cycles = 0;
    always #50 clk = ~clk;
    sdr_host_model host_u (.clk_in(clk), .req_out(req), .valid_out(valid));
    sdr_regs dut_u (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .REQ_VALID_IN(valid),
        .REQ_WR_IN(req.wr), .REQ_ADDR_IN(req.addr), .REQ_DATA_IN(req.data), .RD_DATA_OUT(rd),
        .STEP_ADVANCE_PIN_IN(step), .DIR_PIN_IN(dir), .HEAT_WARNING_IN(ht), .CP_FAIL_IN(cp),
        .COIL_X_UNCONNECTED_IN(ox), .COIL_Y_UNCONNECTED_IN(oy), .LOAD_ANGLE_RAW_IN(la_raw),
        .LOAD_ANGLE_OUTPUT_OUT(la), .BRIDGE_EN_OUT(br), .SLEEP_OUT(slp), .PWM_DOUBLE_OUT(pdbl),
        .PWM_JITTER_OUT(jit), .PWM_FREQ_HZ_X10_OUT(freq), .DIR_CCW_OUT(ccw),
        .STEP_PULSE_OUT(pls), .PEAK_COIL_LEVEL_OUT(lvl), .PEAK_COIL_AMPLITUDE_OUT(amp),
        .EDGE_SLEW_SELECT_OUT(esel), .SLEW_V_PER_US_OUT(slew), .STEP_RESOLUTION_OUT(res),
        .STEP_DIVIDER_OUT(dv), .STEP_COMPENSATED_OUT(comp));
    task automatic complete_run;
        $display("Counts: %0d mismatches in %0d checks", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        host_u.access(1'b1, a, d);
        repeat (3) @(negedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [4:0] a);
        host_u.access(1'b0, a, 8'h00);
        v = rd;
    endtask : rd_reg
    task automatic t_reset;
        repeat (3) @(negedge clk);
        chk(br, 1'b0);
        chk(freq, 9'h0e4);
        chk(slew, 8'h96);
        chk(amp, 10'h00f);
        rd_reg(ADDR_DRV_CTRL);
        chk(v, 8'h00);
        rd_reg(ADDR_FLT_STAT);
        chk(v, 8'h00);
    endtask : t_reset
    task automatic t_control;
        wr_reg(ADDR_DRV_CTRL, 8'hff);
        rd_reg(ADDR_DRV_CTRL);
        chk(v, 8'hf0);
        chk({br, slp}, 2'h3);
        wr_reg(ADDR_DRV_CTRL, 8'h20);
        chk(la, 8'h32);
        chk({br, slp}, 2'h0);
        wr_reg(ADDR_DRV_CTRL, 8'h10);
        la_raw = 8'h3c;
        repeat (3) @(negedge clk);
        chk(la, 8'h32);
        wr_reg(ADDR_DRV_CTRL, 8'h00);
        chk(la, 8'h1e);
    endtask : t_control
    task automatic t_config;
        logic [7:0] s[4] = '{8'h96, 8'h64, 8'h32, 8'h19};
        for (int i = 0; i < 4; i++)
        begin
            dir = i[1];
            wr_reg(ADDR_CFG_PWM, {i[0], 3'h0, i[1], i[0], i[1:0]});
            chk(slew, s[i]);
            chk(esel, i[1:0]);
            chk({freq, jit}, {i[1] ? 9'h1c8 : 9'h0e4, i[0]});
            chk(pdbl, i[1]);
            chk(ccw, i[0] ^ i[1]);
        end
    endtask : t_config
    task automatic t_amp;
        logic [4:0] l[4] = '{5'h00, 5'h01, 5'h10, 5'h1f};
        logic [9:0] a[4] = '{10'h00f, 10'h01e, 10'h0b5, 10'h320};
        logic [5:0] d[7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h02, 6'h01};
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(ADDR_CFG_STEP, {3'h0, l[i]});
            chk(amp, a[i]);
            chk(lvl, l[i]);
        end
        for (int m = 0; m < 7; m++)
        begin
            wr_reg(ADDR_CFG_STEP, {m[2:0], 5'h1f});
            chk({res, dv, comp}, {m[2:0], d[m], m == 5});
        end
        wr_reg(ADDR_CFG_STEP, 8'hff);
        chk({res, dv}, {3'h6, 6'h01});
        rd_reg(ADDR_CFG_STEP);
        chk(v, 8'hff);
    endtask : t_amp
    task automatic pulses(input logic lvl, input int exp);
        int n = 0;
        step = lvl;
        repeat (4)
        begin
            @(negedge clk);
            n += pls;
        end
        chk(n[9:0], exp[9:0]);
    endtask : pulses
    task automatic t_step;
        wr_reg(ADDR_CFG_PWM, 8'h00);
        pulses(1'b1, 1);
        pulses(1'b0, 0);
        wr_reg(ADDR_CFG_PWM, 8'h40);
        pulses(1'b1, 0);
        pulses(1'b0, 1);
    endtask : t_step
    task automatic t_status;
        {ht, cp, ox, oy} = 4'he;
        repeat (3) @(negedge clk);
        rd_reg(ADDR_FLT_STAT);
        chk(v, 8'he8);
        wr_reg(ADDR_FLT_STAT, 8'h00);
        rd_reg(ADDR_FLT_STAT);
        chk(v, 8'he8);
        {ht, cp, ox, oy} = 4'h1;
        repeat (3) @(negedge clk);
        rd_reg(ADDR_FLT_STAT);
        chk(v, 8'h84);
        rd_reg(5'h1f);
        chk(v, 8'h00);
    endtask : t_status
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            complete_run();
        end
    end
    initial
    begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_control();
        t_config();
        t_amp();
        t_step();
        t_status();
        complete_run();
    end
endmodule : testbench
